// *** verilog/rcl_pkg.sv ***
// constants, types and register map of the random colour led strip driver
//
// Overview of operation
// - 16-bit lfsr supplies one random bit per data bit
// - 5-bit bit counter wraps to zero at 25
// - 20 MHz pulse clock gives 1.25 us bits
// - random bit picks short or long high phase
// - ripple counter steps each bit period, divides refresh rate
// - two select switches pick refresh counter tap
// - pulse train drives strip data pin
// - whole strip rewritten each refresh, no command needed
package rcl_pkg;

	// clock rates and bit timing
	localparam int SYS_CLK_HZ = 50_000_000; // system clock rate
	localparam int PULSE_CLK_HZ = 20_000_000; // rate the bit counter steps at
	localparam int BIT_TIME_NS = 1250; // one data bit on the strip
	localparam longint BIT_TICKS_L = (longint'(PULSE_CLK_HZ) * longint'(BIT_TIME_NS))
		/ 64'd1_000_000_000;
	localparam int BIT_TICKS = int'(BIT_TICKS_L); // 25 pulse ticks per bit
	localparam int CNT_W = 5; // bit counter width
	localparam int T0H_TICKS = 8; // high ticks for a zero
	localparam int T1H_TICKS = 16; // high ticks for a one

	// fractional divider: PULSE_CLK_HZ out of SYS_CLK_HZ, in MHz units
	localparam int ACC_W = 7;
	localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(PULSE_CLK_HZ / 1_000_000);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_HZ / 1_000_000);

	// random generator
	localparam int LFSR_W = 16;
	localparam logic [15:0] LFSR_SEED = 16'hACE1; // non-zero start state
	localparam logic [15:0] LFSR_MASK = 16'hB400; // galois taps 16,14,13,11

	// refresh divider and frame size
	localparam int RIPPLE_W = 16;
	localparam int REFRESH_TAP_BASE = 12; // tap for select 00
	localparam int BITS_PER_LED = 24;
	localparam int NUM_LEDS = 8;

	// register map (byte addresses, one word each)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LFSR = 8'h08;
	localparam logic [7:0] REG_RIPPLE = 8'h0C;

	// field positions
	localparam int CTRL_RUN = 0; // strip refresh enabled
	localparam int STAT_SENDING = 0; // frame in progress
	localparam int STAT_RETURN = 1; // sticky, chain return seen high
	localparam int STAT_CLKSEL = 2; // external pulse clock in use
	localparam int STAT_REFSEL = 4; // two bits, refresh select
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// frame sequencer
	typedef enum logic {ST_GAP, ST_SEND} rcl_state_t;

endpackage : rcl_pkg

// *** verilog/rcl_rng_if.sv ***
// signals between the strip sequencer and the random bit generator
`timescale 1ns/1ps
`default_nettype none
interface rcl_rng_if;
	logic advance; // consume current bit, step once
	logic seed_in; // extra entropy mixed into feedback
	logic rnd_bit; // current random bit
	logic [15:0] state; // full generator state
	modport gen (input advance, input seed_in, output rnd_bit, output state);
	modport user (output advance, output seed_in, input rnd_bit, input state);
endinterface : rcl_rng_if
`default_nettype wire

// *** verilog/rcl_lfsr.sv ***
// 16-bit galois lfsr random bit source
`timescale 1ns/1ps
`default_nettype none
module rcl_lfsr
	import rcl_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// generator side of the link
	rcl_rng_if.gen rng
);

	logic [LFSR_W-1:0] lfsr_ff; // shift state
	logic [LFSR_W-1:0] nxt_lfsr; // state after one step
	logic fb; // feedback bit

	// seed input is xored in so a pin can stir the sequence
	assign fb = lfsr_ff[0] ^ rng.seed_in;
	// an all-zero state would lock up; reload the seed instead
	assign nxt_lfsr = (({1'b0, lfsr_ff[LFSR_W-1:1]} ^ (fb ? LFSR_MASK : '0)) == '0) ?
		LFSR_SEED : ({1'b0, lfsr_ff[LFSR_W-1:1]} ^ (fb ? LFSR_MASK : '0));

	// one step per consumed data bit
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lfsr_ff <= LFSR_SEED;
		end else if (rng.advance) begin
			lfsr_ff <= nxt_lfsr;
		end
	end

	assign rng.rnd_bit = lfsr_ff[0];
	assign rng.state = lfsr_ff;

endmodule : rcl_lfsr
`default_nettype wire

// *** verilog/rcl_strip_top.sv ***
// random colour led strip driver with wishbone register slave
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcl_strip_top
	import rcl_pkg::*;
#(
	parameter int NUM_LEDS_P = NUM_LEDS, // leds in the chain
	parameter int T0H_P = T0H_TICKS, // high ticks for a zero bit
	parameter int T1H_P = T1H_TICKS, // high ticks for a one bit
	parameter int REFRESH_TAP_P = REFRESH_TAP_BASE // ripple bit used with select 00
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// wishbone classic slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// asynchronous pins
	input wire logic i_clock_source_select,
	input wire logic i_external_clock,
	input wire logic i_refresh_select_low_switch,
	input wire logic i_refresh_select_high_switch,
	input wire logic i_chain_return_pin,
	input wire logic i_random_seed_pin,
	// strip side
	output logic o_strip_data_pin,
	output logic o_random_bit,
	output logic o_random_shift_strobe,
	output logic o_strip_overflow,
	output logic o_strip_refresh
);

	localparam int FRAME_BITS = NUM_LEDS_P * BITS_PER_LED;
	localparam int IDX_W = $clog2(FRAME_BITS);
	localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_TICKS - 1);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(FRAME_BITS - 1);
	localparam logic [CNT_W-1:0] T0H_C = CNT_W'(T0H_P);
	localparam logic [CNT_W-1:0] T1H_C = CNT_W'(T1H_P);
	localparam int NPIN = 6;

	// refuse settings the counters cannot serve
	if (T0H_P < 1 || T0H_P >= T1H_P || T1H_P >= BIT_TICKS || FRAME_BITS < 2 ||
		REFRESH_TAP_P + 3 >= RIPPLE_W ||
		FRAME_BITS >= (1 << REFRESH_TAP_P)) begin : g_bad_cfg
		$error("rcl_strip_top: bad pulse widths or frame too long for refresh");
	end

	// pin synchronisers: two flops per pin, third for the clock and chain return edges
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic ext_d_ff; // previous synced external clock
	logic ret_d_ff; // previous synced chain return
	assign pins = {i_random_seed_pin, i_chain_return_pin, i_refresh_select_high_switch,
		i_refresh_select_low_switch, i_external_clock, i_clock_source_select};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pins[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	wire clk_sel_req = sync2_ff[0]; // wanted pulse clock source
	wire ext_clk_s = sync2_ff[1];
	wire [1:0] ref_sel = sync2_ff[3:2]; // {high, low} switch
	wire chain_ret_s = sync2_ff[4];
	wire seed_s = sync2_ff[5];

	// state
	logic [ACC_W-1:0] acc_ff; // fractional divider phase
	logic [CNT_W-1:0] bitcnt_ff; // position inside one bit
	logic [RIPPLE_W-1:0] ripple_ff; // refresh divider
	logic tap_d_ff; // previous value of the chosen tap
	logic clk_sel_ff; // pulse clock source in use
	logic pend_ff; // refresh seen, waiting for a bit boundary
	logic [IDX_W-1:0] idx_ff; // bit index inside the frame
	rcl_state_t state_ff;
	logic run_ff; // software enable
	logic ret_seen_ff; // sticky chain return flag
	logic [31:0] rdat_ff;
	logic ack_ff;

	// generator link
	rcl_rng_if rng ();
	rcl_lfsr u_lfsr (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.rng(rng)
	);

	// pulse tick: 20 of every 50 system cycles, or each external rising edge
	wire [ACC_W:0] acc_sum = {1'b0, acc_ff} + {1'b0, ACC_INC};
	wire sys_tick = acc_sum >= {1'b0, ACC_MOD};
	wire [ACC_W-1:0] nxt_acc = sys_tick ? ACC_W'(acc_sum - {1'b0, ACC_MOD}) :
		acc_sum[ACC_W-1:0];
	wire ext_rise = ext_clk_s & ~ext_d_ff;
	wire tick = clk_sel_ff ? ext_rise : sys_tick;
	wire period_end = tick && (bitcnt_ff == BIT_LAST);
	wire [CNT_W-1:0] nxt_bitcnt = period_end ? '0 : (tick ? bitcnt_ff + 1'b1 : bitcnt_ff);

	// refresh tap and its rising edge
	wire tap_bit = ripple_ff[REFRESH_TAP_P + int'(ref_sel)];
	wire refresh_evt = tap_bit & ~tap_d_ff;
	wire overflow_evt = period_end && (ripple_ff == '1);

	// frame control
	wire start_frame = (state_ff == ST_GAP) && pend_ff && run_ff && period_end;
	wire last_bit = (state_ff == ST_SEND) && period_end && (idx_ff == IDX_LAST);
	wire [CNT_W-1:0] hi_len = rng.rnd_bit ? T1H_C : T0H_C;
	wire nxt_data = (state_ff == ST_SEND) && (bitcnt_ff < hi_len);
	assign rng.advance = (state_ff == ST_SEND) && period_end;
	assign rng.seed_in = seed_s;

	// register decode
	wire wb_req = i_wb_cyc & i_wb_stb;
	wire wb_wr = wb_req & ack_ff & i_wb_we; // write lands on the ack edge
	wire hit_ctrl = i_wb_adr == REG_CTRL;
	wire hit_stat = i_wb_adr == REG_STATUS;
	wire clr_ret = wb_wr && hit_stat && i_wb_sel[0] && i_wb_dat[STAT_RETURN];
	wire ret_rise = chain_ret_s & ~ret_d_ff;
	wire [31:0] stat_word = {26'h0, ref_sel, 1'b0, clk_sel_ff, ret_seen_ff,
		state_ff == ST_SEND};
	wire [31:0] rd_mux = hit_ctrl ? {31'h0, run_ff} :
		hit_stat ? stat_word :
		(i_wb_adr == REG_LFSR) ? {16'h0, rng.state} :
		(i_wb_adr == REG_RIPPLE) ? {16'h0, ripple_ff} : 32'h0;

	// pulse timing: divider, bit counter, source switch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_ff <= '0;
			bitcnt_ff <= '0;
			ext_d_ff <= 1'b0;
			clk_sel_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			bitcnt_ff <= nxt_bitcnt;
			ext_d_ff <= ext_clk_s;
			// only switch at a bit boundary or while the line idles low,
			// so no data pulse is ever cut short or stretched
			if (period_end || state_ff == ST_GAP) begin
				clk_sel_ff <= clk_sel_req;
			end
		end
	end

	// refresh divider; built synchronous, one step at the end of every bit period, sending or idle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ripple_ff <= '0;
			tap_d_ff <= 1'b0;
		end else begin
			if (period_end) begin
				ripple_ff <= ripple_ff + 1'b1;
			end
			tap_d_ff <= tap_bit;
		end
	end

	// frame sequencer: wait for refresh, then send every bit of the chain
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= ST_GAP;
			pend_ff <= 1'b0;
			idx_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_GAP: begin
					// a refresh landing during a frame is dropped on purpose
					if (start_frame) begin
						pend_ff <= 1'b0;
						idx_ff <= '0;
						state_ff <= ST_SEND;
					end else if (refresh_evt) begin
						pend_ff <= 1'b1;
					end
				end
				ST_SEND: begin
					if (last_bit) begin
						state_ff <= ST_GAP; // line idles low, which latches the leds
					end else if (period_end) begin
						idx_ff <= idx_ff + 1'b1;
					end
				end
			endcase
		end
	end

	// strip outputs, all registered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_strip_data_pin <= 1'b0;
			o_random_bit <= 1'b0;
			o_random_shift_strobe <= 1'b0;
			o_strip_overflow <= 1'b0;
			o_strip_refresh <= 1'b0;
		end else begin
			o_strip_data_pin <= nxt_data;
			o_random_bit <= rng.rnd_bit;
			o_random_shift_strobe <= rng.advance;
			o_strip_overflow <= overflow_evt;
			o_strip_refresh <= refresh_evt;
		end
	end

	// chain return is only watched; nothing waits on it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ret_d_ff <= 1'b0;
			ret_seen_ff <= 1'b0;
		end else begin
			ret_d_ff <= chain_ret_s;
			if (ret_rise) begin
				ret_seen_ff <= 1'b1;
			end else if (clr_ret) begin
				ret_seen_ff <= 1'b0;
			end
		end
	end

	// wishbone slave: ack one cycle after the request, dropped after one
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_ff <= 1'b0;
			rdat_ff <= '0;
			run_ff <= CTRL_RESET[CTRL_RUN];
		end else begin
			ack_ff <= wb_req & ~ack_ff;
			if (wb_req && !ack_ff) begin
				rdat_ff <= rd_mux;
			end
			if (wb_wr && hit_ctrl && i_wb_sel[0]) begin
				run_ff <= i_wb_dat[CTRL_RUN];
			end
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

endmodule : rcl_strip_top
`default_nettype wire

// *** sim/rcl_strip_checker.sv ***
// concurrent checks on the strip driver's top-level ports
`timescale 1ns/1ps
`default_nettype none
module rcl_strip_checker (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// bus handshake
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	// strip side
	input wire logic o_strip_data_pin,
	input wire logic o_random_shift_strobe,
	input wire logic o_strip_overflow,
	input wire logic o_strip_refresh
);
	localparam int HI_MAX = 60; // longest high phase at the slowest tick spacing
	localparam int TO_END = 80; // fall of a pulse to the end of its bit
	localparam int TO_SEND = 90; // refresh to the next bit boundary, plus the register
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// a request not yet answered
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// a zero bit is at least eight ticks, so at least eight cycles high
	sequence s_short_high;
		o_strip_data_pin [*8];
	endsequence
	chk_ack_follows: assert property (s_req |=> o_wb_ack)
		else $error("ack did not follow a request");
	chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	chk_strobe_pulse: assert property (o_random_shift_strobe |=> !o_random_shift_strobe)
		else $error("shift strobe longer than one cycle");
	chk_bit_consumed: assert property ($fell(o_strip_data_pin) |-> ##[1:TO_END] o_random_shift_strobe)
		else $error("no random step at the end of a bit");
	chk_high_min: assert property ($rose(o_strip_data_pin) |-> s_short_high)
		else $error("high phase too short");
	chk_high_max: assert property ($rose(o_strip_data_pin) |-> ##[1:HI_MAX] !o_strip_data_pin)
		else $error("high phase too long");
	chk_refresh_pulse: assert property (o_strip_refresh |=> !o_strip_refresh)
		else $error("refresh longer than one cycle");
	chk_overflow_pulse: assert property (o_strip_overflow |=> !o_strip_overflow)
		else $error("overflow longer than one cycle");
	chk_refresh_sends: assert property (o_strip_refresh |-> ##[1:TO_SEND] $rose(o_strip_data_pin))
		else $error("refresh did not start a frame");
endmodule : rcl_strip_checker
`default_nettype wire

// *** sim/rcl_led_chain.sv ***
// behavioural led chain: decodes strip pulses, forwards bits past the first led
`timescale 1ns/1ps
`default_nettype none
module rcl_led_chain #(
	parameter int BIT_CYC = 50, // system cycles per bit with the external tick
	parameter int HI0_CYC = 16, // high cycles for a zero
	parameter int HI1_CYC = 32, // high cycles for a one
	parameter int OWN_BITS = 24 // bits kept by the first led
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// strip line in, chain return out
	input wire logic i_din,
	output logic o_dout,
	// decoded traffic
	output logic [15:0] o_nbits,
	output logic [47:0] o_word,
	output logic o_bad
);
	logic din_q; // line level one cycle ago
	int hi; // cycles high in the current pulse
	int per; // cycles since the last rising edge
	// measure each pulse; the bit value is read from its width at the fall
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{din_q, o_nbits, o_word, o_bad} <= '0;
			hi <= 0;
			per <= 0;
		end else begin
			din_q <= i_din;
			hi <= i_din ? hi + 1 : 0;
			per <= (i_din && !din_q) ? 1 : per + 1;
			// bits inside a frame follow each other at a fixed period
			if (i_din && !din_q && o_nbits != 0 && per < 2 * BIT_CYC && per != BIT_CYC) begin
				o_bad <= 1'b1;
			end
			if (!i_din && din_q) begin
				o_word <= {o_word[46:0], hi > (HI0_CYC + HI1_CYC) / 2};
				o_nbits <= o_nbits + 16'h0001;
				o_bad <= o_bad | (hi != HI0_CYC && hi != HI1_CYC);
			end
		end
	end
	// a real led forwards only what follows its own bits, so the return is low until then
	assign o_dout = (o_nbits >= OWN_BITS) && i_din;
endmodule : rcl_led_chain
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking testbench for the random colour strip driver
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act, exp) begin \
	num_checks++; \
	if ((act) !== (exp)) begin \
		failures++; \
		$display("unexpected at %0t ns: got %h, expected %h", $time, act, exp); \
	end \
end
module testbench;
	import rcl_pkg::*;
	logic i_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
	logic [7:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat, o_wb_dat, rd, r0;
	logic i_clock_source_select, i_external_clock, i_chain_return_pin;
	logic i_refresh_select_low_switch, i_refresh_select_high_switch, i_random_seed_pin;
	logic o_strip_data_pin, o_random_shift_strobe, o_strip_overflow, o_strip_refresh;
	logic [15:0] nbits, nstrobe, s;
	logic [47:0] word, exp_word;
	logic bad, rbit;
	int failures = 0;
	int num_checks = 0;
	int n;
	localparam int TAP = 8; // low refresh tap keeps the first refresh near 12.8k cycles
	// two leds in the frame, one led in the chain, so half the frame comes back
	rcl_strip_top #(.NUM_LEDS_P(2), .REFRESH_TAP_P(TAP)) rcl_strip_top_inst (.i_clk,
		.i_rst_n, .i_wb_cyc,
		.i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack,
		.i_clock_source_select, .i_external_clock, .i_refresh_select_low_switch,
		.i_refresh_select_high_switch, .i_chain_return_pin, .i_random_seed_pin,
		.o_strip_data_pin, .o_random_bit(rbit), .o_random_shift_strobe, .o_strip_overflow,
		.o_strip_refresh);
	rcl_led_chain rcl_led_chain_inst (.i_clk, .i_rst_n, .i_din(o_strip_data_pin),
		.o_dout(i_chain_return_pin), .o_nbits(nbits), .o_word(word), .o_bad(bad));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// external tick every second cycle: 50-cycle bits, the fastest the synchroniser allows
	always @(posedge i_clk) begin
		i_external_clock <= ~i_external_clock;
		if (o_random_shift_strobe === 1'b1) nstrobe <= nstrobe + 16'h0001;
	end
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		k = 0;
		@(posedge i_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, adr, dat};
		do begin
			@(posedge i_clk);
			k++;
		end while (o_wb_ack !== 1'b1 && k < 50);
		rd = o_wb_dat;
		{i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
		if (k >= 50) failures++;
	endtask : wb
	task automatic results;
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// a hang ends the run; the whole sequence needs about 16k cycles
	initial begin
		repeat (40000) @(posedge i_clk);
		failures++;
		results();
	end
	initial begin
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = '0;
		{i_rst_n, i_external_clock, i_random_seed_pin, nstrobe} = '0;
		{i_refresh_select_low_switch, i_refresh_select_high_switch} = 2'b00;
		i_clock_source_select = 1'b1;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		i_wb_sel <= 4'hF;
		wb(1'b0, REG_CTRL, 32'h0);
		`CHECK(rd, 32'h0000_0001)
		wb(1'b0, REG_LFSR, 32'h0);
		`CHECK(rd, 32'h0000_ACE1)
		wb(1'b1, 8'h10, 32'hFFFF_FFFF);
		wb(1'b0, 8'h10, 32'h0);
		`CHECK(rd, 32'h0000_0000)
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b0, REG_CTRL, 32'h0);
		`CHECK(rd, 32'h0000_0000)
		wb(1'b1, REG_CTRL, 32'h1);
		// both selects up, then back down, before any tap can rise
		{i_refresh_select_low_switch, i_refresh_select_high_switch} <= 2'b11;
		repeat (4) @(posedge i_clk);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0034)
		{i_refresh_select_low_switch, i_refresh_select_high_switch} <= 2'b00;
		repeat (4) @(posedge i_clk);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0004)
		// ripple counter advances once per 50-cycle bit
		wb(1'b0, REG_RIPPLE, 32'h0);
		r0 = rd;
		repeat (500) @(posedge i_clk);
		wb(1'b0, REG_RIPPLE, 32'h0);
		`CHECK((rd - r0) inside {[32'd9:32'd11]}, 1'b1)
		n = 0;
		while (o_strip_refresh !== 1'b1 && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 20000) failures++;
		wb(1'b0, REG_RIPPLE, 32'h0);
		`CHECK(rd >> TAP, 32'h0000_0001)
		repeat (2600) @(posedge i_clk);
		// expected frame: the galois sequence from the seed, one bit per step
		s = LFSR_SEED;
		exp_word = '0;
		for (int i = 0; i < 48; i++) begin
			exp_word = {exp_word[46:0], s[0]};
			s = {1'b0, s[15:1]} ^ (s[0] ? LFSR_MASK : 16'h0000);
		end
		`CHECK(nbits, 16'd48)
		`CHECK(bad, 1'b0)
		`CHECK(word, exp_word)
		`CHECK(nstrobe, 16'd48)
		`CHECK(o_strip_data_pin, 1'b0)
		wb(1'b0, REG_LFSR, 32'h0);
		`CHECK(rd, {16'h0000, s})
		`CHECK(rbit, s[0])
		wb(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0006)
		wb(1'b1, REG_STATUS, 32'h0000_0002);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0004)
		// internal pulse clock: 20 ticks per 50 cycles, so about ten bits in 628 cycles
		i_clock_source_select <= 1'b0;
		repeat (4) @(posedge i_clk);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHECK(rd, 32'h0000_0000)
		wb(1'b0, REG_RIPPLE, 32'h0);
		r0 = rd;
		repeat (625) @(posedge i_clk);
		wb(1'b0, REG_RIPPLE, 32'h0);
		`CHECK((rd - r0) inside {[32'd9:32'd11]}, 1'b1)
		results();
	end
endmodule : testbench
bind rcl_strip_top rcl_strip_checker rcl_strip_checker_inst (.i_clk, .i_rst_n, .i_wb_cyc,
	.i_wb_stb, .o_wb_ack, .o_strip_data_pin, .o_random_shift_strobe, .o_strip_overflow,
	.o_strip_refresh);
`default_nettype wire
